// ---- hw/eivs_pkg.sv ----
// Constants, register map and carrier types for the external interrupt
// front end and vector table select. Assumes a byte-wide register port.
// Notes on behaviour
// - Select bit picks flash start or boot
// - Mask interrupts during unlock window and after
// - Global enable bit untouched by auto masking
// - Unlock clears after four cycles or select
// - Boot lock bits block cross-section interrupts
// - Pins trigger even when driven as outputs
// - Three pin-change banks, per-pin masks
// - Pin-change detect works without I/O clock; here it compares synchronised samples on clk
// - Level mode requests while pin stays low
// - Edge detection needs running clock
// - Low-level detection is asynchronous; here the pin passes the two-stage synchroniser on clk
// - Level must persist through wake start-up
// - Global enable and own mask both needed
// - Pins sampled before edge detection
// - Pin B sense in bits three, two
// - Pin A sense in bits one, zero
// - Unused sense and mask bits read zero
// - Mask bit one pin B, zero pin A
// - Flags set on event, clear on ack/one
// - Group enable gates bank, pin masks select
package eivs_pkg;
   localparam logic [7:0] EIVS_ADDR_MASK    = 8'h3D;
   localparam logic [7:0] EIVS_ADDR_CPUCTL  = 8'h55;
   localparam logic [7:0] EIVS_ADDR_SENSE   = 8'h69;
   localparam logic [7:0] EIVS_ADDR_GRP_EN  = 8'h68;
   localparam logic [7:0] EIVS_ADDR_MSK_LO  = 8'h6B;
   localparam logic [7:0] EIVS_ADDR_MSK_MID = 8'h6C;
   localparam logic [7:0] EIVS_ADDR_MSK_HI  = 8'h6D;
   localparam logic [7:0] EIVS_ADDR_EXT_FLG = 8'h3C;
   localparam logic [7:0] EIVS_ADDR_PC_FLG  = 8'h3B;
   localparam int         EIVS_SEL_BIT      = 1;
   localparam int         EIVS_UNLOCK_BIT   = 0;
   localparam logic [7:0] EIVS_RESET_VAL    = 8'h00;
   localparam logic [2:0] EIVS_UNLOCK_CYC   = 3'h4;
   localparam logic [2:0] EIVS_POST_CYC     = 3'h2;
   localparam logic [1:0] EIVS_SNS_LOW      = 2'h0;
   localparam logic [1:0] EIVS_SNS_ANY      = 2'h1;
   localparam logic [1:0] EIVS_SNS_FALL     = 2'h2;
   localparam logic [1:0] EIVS_SNS_RISE     = 2'h3;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } eivs_bus_t;

   typedef struct packed {
      logic [1:0] ext_ack;
      logic [2:0] pc_ack;
      logic       global_enable;
      logic       exec_in_boot;
      logic       app_side_boot_lock;
      logic       boot_side_boot_lock;
   } eivs_cpu_t;
endpackage : eivs_pkg

// ---- hw/eivs_sync.sv ----
// Two-stage synchroniser for a vector of asynchronous levels.
// Assumes inputs may change at any time relative to clk.
`timescale 1ns/1ns
`default_nettype none
module eivs_sync #(parameter int W = 26) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   import eivs_pkg::*;
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } eivs_sync_st_t;
   eivs_sync_st_t st;
   eivs_sync_st_t next_st;

   always_comb begin
      next_st.s1 = d;
      next_st.s2 = st.s1;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign q = st.s2;
endmodule : eivs_sync
`default_nettype wire

// ---- hw/eivs_top.sv ----
// External interrupt front end with vector table select sequence.
// Pins are asynchronous; CPU acks and status arrive synchronous to clk.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module eivs_top (
   input  wire logic                clk,
   input  wire logic                rst_n,
   input  wire eivs_pkg::eivs_bus_t bus,
   input  wire eivs_pkg::eivs_cpu_t cpu,
   input  wire logic [1:0]          ext_irq_pins,
   input  wire logic [23:0]         pin_change_inputs,
   output logic [7:0]               rdata,
   output logic [4:0]               irq_req,
   output logic                     irq_block,
   output logic                     vector_table_select,
   output logic                     wake
);
   import eivs_pkg::*;

   typedef struct packed {
      logic [1:0]  ext_mask;
      logic [3:0]  sense;
      logic [2:0]  grp_en;
      logic [7:0]  msk_lo;
      logic [6:0]  msk_mid;
      logic [7:0]  msk_hi;
      logic [1:0]  ext_flag;
      logic [2:0]  pc_flag;
      logic        sel;
      logic        unlock;
      logic [2:0]  unlock_cnt;
      logic [2:0]  post_cnt;
      logic [1:0]  ext_prev;
      logic [23:0] pc_prev;
      logic        primed;
      logic [7:0]  rdata;
      logic [4:0]  irq_req;
      logic        irq_block;
      logic        wake;
   } eivs_st_t;

   eivs_st_t    st;
   eivs_st_t    next_st;
   logic [25:0] synced;
   logic [1:0]  ext_s;
   logic [23:0] pc_s;
   logic [1:0]  ext_evt;
   logic [2:0]  pc_evt;
   logic [1:0]  ext_level;
   logic [23:0] pc_en_vec;
   logic [23:0] pc_toggle;
   logic        auto_mask;
   logic        lock_block;

   // Pins and level lines through the synchroniser
   eivs_sync #(.W(26)) u_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .d     ({ext_irq_pins, pin_change_inputs}),
      .q     (synced)
   );
   assign ext_s = synced[25:24];
   assign pc_s  = synced[23:0];

   function automatic logic edge_hit(input logic [1:0] mode, input logic cur,
                                     input logic prev);
      case (mode)
         EIVS_SNS_ANY:  edge_hit = cur ^ prev;
         EIVS_SNS_FALL: edge_hit = prev & ~cur;
         EIVS_SNS_RISE: edge_hit = cur & ~prev;
         default:       edge_hit = 1'b0;
      endcase
   endfunction : edge_hit

   function automatic logic [7:0] reg_read(input eivs_st_t s, input logic [7:0] a);
      case (a)
         EIVS_ADDR_MASK:    reg_read = {6'h00, s.ext_mask};
         EIVS_ADDR_CPUCTL:  reg_read = {6'h00, s.sel, s.unlock};
         EIVS_ADDR_SENSE:   reg_read = {4'h0, s.sense};
         EIVS_ADDR_GRP_EN:  reg_read = {5'h00, s.grp_en};
         EIVS_ADDR_MSK_LO:  reg_read = s.msk_lo;
         EIVS_ADDR_MSK_MID: reg_read = {1'b0, s.msk_mid};
         EIVS_ADDR_MSK_HI:  reg_read = s.msk_hi;
         EIVS_ADDR_EXT_FLG: reg_read = {6'h00, s.ext_flag};
         EIVS_ADDR_PC_FLG:  reg_read = {5'h00, s.pc_flag};
         default:           reg_read = 8'h00;
      endcase
   endfunction : reg_read

   // Pin inputs are observed regardless of pin direction
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         ext_level[i] = st.sense[2*i +: 2] == EIVS_SNS_LOW;
         ext_evt[i]   = st.primed && !ext_level[i]
                        && edge_hit(st.sense[2*i +: 2], ext_s[i], st.ext_prev[i]);
      end
   end

   assign pc_en_vec = {st.msk_hi, 1'b0, st.msk_mid, st.msk_lo};
   assign pc_toggle = st.primed ? ((pc_s ^ st.pc_prev) & pc_en_vec) : 24'h000000;

   always_comb begin
      pc_evt[2] = |pc_toggle[23:16];
      pc_evt[1] = |pc_toggle[14:8];
      pc_evt[0] = |pc_toggle[7:0];
   end

   assign auto_mask = st.unlock || (st.post_cnt != 3'h0);
   assign lock_block = (st.sel && cpu.app_side_boot_lock && !cpu.exec_in_boot)
                       || (!st.sel && cpu.boot_side_boot_lock && cpu.exec_in_boot);

   always_comb begin
      next_st = st;
      next_st.ext_prev = ext_s;
      next_st.pc_prev  = pc_s;
      next_st.primed   = 1'b1;

      // Unlock window countdown
      if (st.unlock) begin
         if (st.unlock_cnt <= 3'h1) begin
            next_st.unlock = 1'b0;
            next_st.unlock_cnt = 3'h0;
         end else begin
            next_st.unlock_cnt = st.unlock_cnt - 3'h1;
         end
      end
      if (st.post_cnt != 3'h0) begin
         next_st.post_cnt = st.post_cnt - 3'h1;
      end

      // Flags: acks and write-one clears first, events win after
      if (bus.wr && bus.addr == EIVS_ADDR_EXT_FLG) begin
         next_st.ext_flag = st.ext_flag & ~bus.wdata[1:0];
      end
      if (bus.wr && bus.addr == EIVS_ADDR_PC_FLG) begin
         next_st.pc_flag = st.pc_flag & ~bus.wdata[2:0];
      end
      next_st.ext_flag = (next_st.ext_flag & ~cpu.ext_ack) | ext_evt;
      next_st.pc_flag  = (next_st.pc_flag & ~cpu.pc_ack) | pc_evt;

      if (bus.wr) begin
         case (bus.addr)
            EIVS_ADDR_MASK:    next_st.ext_mask = bus.wdata[1:0];
            EIVS_ADDR_SENSE:   next_st.sense = bus.wdata[3:0];
            EIVS_ADDR_GRP_EN:  next_st.grp_en = bus.wdata[2:0];
            EIVS_ADDR_MSK_LO:  next_st.msk_lo = bus.wdata;
            EIVS_ADDR_MSK_MID: next_st.msk_mid = bus.wdata[6:0];
            EIVS_ADDR_MSK_HI:  next_st.msk_hi = bus.wdata;
            EIVS_ADDR_CPUCTL: begin
               if (bus.wdata[EIVS_UNLOCK_BIT]) begin
                  next_st.unlock     = 1'b1;
                  next_st.unlock_cnt = EIVS_UNLOCK_CYC;
               end else if (st.unlock) begin
                  next_st.sel        = bus.wdata[EIVS_SEL_BIT];
                  next_st.unlock     = 1'b0;
                  next_st.unlock_cnt = 3'h0;
                  next_st.post_cnt   = EIVS_POST_CYC;
               end
            end
            default: begin
            end
         endcase
      end

      // Level mode keeps its flag clear
      for (int i = 0; i < 2; i++) begin
         if (next_st.sense[2*i +: 2] == EIVS_SNS_LOW) begin
            next_st.ext_flag[i] = 1'b0;
         end
      end

      next_st.rdata = bus.rd ? reg_read(st, bus.addr) : 8'h00;
      for (int i = 0; i < 2; i++) begin
         next_st.irq_req[i] = cpu.global_enable && st.ext_mask[i]
                              && (ext_level[i] ? !ext_s[i] : st.ext_flag[i]);
      end
      for (int g = 0; g < 3; g++) begin
         next_st.irq_req[2+g] = cpu.global_enable && st.grp_en[g] && st.pc_flag[g];
      end
      next_st.irq_block = auto_mask || lock_block;
      // Wake on a masked-in low level while it lasts, or any pin change enabled in the pin masks; wake drops once the level leaves
      next_st.wake = |({ext_level & ~ext_s & st.ext_mask} ) || (|pc_toggle);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign rdata               = st.rdata;
   assign irq_req             = st.irq_req;
   assign irq_block           = st.irq_block;
   assign vector_table_select = st.sel;
   assign wake                = st.wake;
endmodule : eivs_top
`default_nettype wire

// ---- verification/eivs_properties.sv ----
// Port checks of the interrupt front end, bound to eivs_top.
// Assumes one clock domain, reset active low and asynchronous.
`timescale 1ns/1ns
`default_nettype none
module eivs_properties (
   input wire logic                clk,
   input wire logic                rst_n,
   input wire eivs_pkg::eivs_bus_t bus,
   input wire eivs_pkg::eivs_cpu_t cpu,
   input wire logic [7:0]          rdata,
   input wire logic [4:0]          irq_req,
   input wire logic                irq_block,
   input wire logic                vector_table_select
);
   import eivs_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_unlock; bus.wr && bus.addr == EIVS_ADDR_CPUCTL && bus.wdata[0]; endsequence
   sequence s_select; bus.wr && bus.addr == EIVS_ADDR_CPUCTL && !bus.wdata[0]; endsequence
   property p_rdata_idle; !bus.rd |=> rdata == 8'h00; endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("rdata not idle");
   property p_sense_rsvd; bus.rd && bus.addr == EIVS_ADDR_SENSE |=> rdata[7:4] == 4'h0; endproperty
   a_sense_rsvd: assert property (p_sense_rsvd) else $error("sense spare bits");
   property p_unlock_block; s_unlock ##1 1'b1 |=> irq_block [*3]; endproperty
   a_unlock_block: assert property (p_unlock_block) else $error("no unlock mask");
   property p_select_hold; s_unlock ##[1:2] s_select |=> irq_block [*2]; endproperty
   a_select_hold: assert property (p_select_hold) else $error("mask after select");
   property p_unlock_end;
      s_unlock ##1 (!(bus.wr && bus.addr == EIVS_ADDR_CPUCTL) && !cpu.app_side_boot_lock
         && !cpu.boot_side_boot_lock) [*8] |-> !irq_block;
   endproperty
   a_unlock_end: assert property (p_unlock_end) else $error("mask too long");
   property p_select_change;
      $changed(vector_table_select) |-> ($past(irq_block) || $past(bus.wr && bus.wdata[0]
         && bus.addr == EIVS_ADDR_CPUCTL, 2)) && $past(bus.wr && !bus.wdata[0]
         && bus.addr == EIVS_ADDR_CPUCTL) && vector_table_select == $past(bus.wdata[1]);
   endproperty
   a_select_change: assert property (p_select_change) else $error("bad select");
   property p_gie_gate; irq_req != 5'h00 |-> $past(cpu.global_enable); endproperty
   a_gie_gate: assert property (p_gie_gate) else $error("request without enable");
   property p_lock_block;
      (vector_table_select && cpu.app_side_boot_lock && !cpu.exec_in_boot)
         || (!vector_table_select && cpu.boot_side_boot_lock && cpu.exec_in_boot) |=> irq_block;
   endproperty
   a_lock_block: assert property (p_lock_block) else $error("lock not blocking");
endmodule : eivs_properties
bind eivs_top eivs_properties u_props (.clk(clk), .rst_n(rst_n), .bus(bus), .cpu(cpu),
   .rdata(rdata), .irq_req(irq_req), .irq_block(irq_block),
   .vector_table_select(vector_table_select));
`default_nettype wire

// ---- verification/eivs_pins_model.sv ----
// Board-side drivers of the dedicated and pin-change inputs.
// Assumes the bench calls drive() at a rising clock edge.
`timescale 1ns/1ns
`default_nettype none
module eivs_pins_model (
   input  wire logic  clk,
   output var logic [1:0]  ext_irq_pins,
   output var logic [23:0] pin_change_inputs
);
   initial begin
      ext_irq_pins = 2'h3;
      pin_change_inputs = 24'h000000;
   end
   task automatic drive(input logic [1:0] e, input logic [23:0] p);
      ext_irq_pins <= e;
      pin_change_inputs <= p;
      repeat (5) @(posedge clk);
   endtask : drive
endmodule : eivs_pins_model
`default_nettype wire

// ---- verification/eivs_top_bench.sv ----
// Self-checking bench of the interrupt front end.
// Assumes the pin model and the bound checker.
`timescale 1ns/1ns
`default_nettype none
module eivs_top_bench;
   import eivs_pkg::*;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   eivs_bus_t   bus = '0;
   eivs_cpu_t   cpu = '0;
   logic [1:0]  pins;
   logic [23:0] pcin;
   logic [7:0]  rdata;
   logic [4:0]  irq_req;
   logic        irq_block;
   logic        vts;
   logic        wake;
   int          miscompares = 0;
   int          samples_checked = 0;
   int          pn[5] = '{15, 22, 0, 14, 23};
   logic [7:0]  pf[5] = '{8'h00, 8'h00, 8'h01, 8'h02, 8'h04};
   logic [7:0]  ra[5] = '{8'h69, 8'h3D, 8'h6C, 8'h68, 8'h70};
   logic [7:0]  rv[5] = '{8'h0F, 8'h03, 8'h7F, 8'h07, 8'h00};
   eivs_pins_model u_pins (.clk(clk), .ext_irq_pins(pins), .pin_change_inputs(pcin));
   eivs_top u_dut (.clk(clk), .rst_n(rst_n), .bus(bus), .cpu(cpu), .ext_irq_pins(pins),
      .pin_change_inputs(pcin), .rdata(rdata), .irq_req(irq_req), .irq_block(irq_block),
      .vector_table_select(vts), .wake(wake));
   initial forever #10 clk = ~clk;
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic obs(input string n, input logic [7:0] e);
      #1;
      chk(n, e, n == "irq_req" ? {3'h0, irq_req} : n == "irq_block" ? {7'h0, irq_block}
         : n == "wake" ? {7'h0, wake} : {7'h0, vts});
      @(posedge clk);
   endtask : obs
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus <= {a, d, 2'h2};
      @(posedge clk);
      bus <= '0;
      @(posedge clk);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      bus <= {a, 8'h00, 2'h1};
      @(posedge clk);
      bus <= '0;
      #1;
      chk("rdata", e, rdata);
      @(posedge clk);
   endtask : rd
   task automatic finish_test;
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : finish_test
   initial begin
      #400000;
      miscompares++;
      finish_test;
   end
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      cpu.global_enable <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         rd(ra[i], 8'h00);
         wr(ra[i], 8'hFF);
         rd(ra[i], rv[i]);
      end
      $display("registers done");
      wr(EIVS_ADDR_CPUCTL, 8'h01);
      wr(EIVS_ADDR_CPUCTL, 8'h02);
      rd(EIVS_ADDR_CPUCTL, 8'h02);
      obs("select", 8'h01);
      wr(EIVS_ADDR_CPUCTL, 8'h00);
      rd(EIVS_ADDR_CPUCTL, 8'h02);
      wr(EIVS_ADDR_CPUCTL, 8'h01);
      repeat (6) @(posedge clk);
      obs("irq_block", 8'h00);
      wr(EIVS_ADDR_CPUCTL, 8'h00);
      rd(EIVS_ADDR_CPUCTL, 8'h02);
      wr(EIVS_ADDR_CPUCTL, 8'h01);
      wr(EIVS_ADDR_CPUCTL, 8'h00);
      rd(EIVS_ADDR_CPUCTL, 8'h00);
      $display("vector select done");
      for (int m = 0; m < 4; m++) begin
         wr(EIVS_ADDR_SENSE, {4'h0, 2'(m), 2'(m)});
         wr(EIVS_ADDR_EXT_FLG, 8'h03);
         rd(EIVS_ADDR_EXT_FLG, 8'h00);
         u_pins.drive(2'h0, pcin);
         rd(EIVS_ADDR_EXT_FLG, (m == 1 || m == 2) ? 8'h03 : 8'h00);
         obs("irq_req", (m != 3) ? 8'h03 : 8'h00);
         obs("wake", (m == 0) ? 8'h01 : 8'h00);
         u_pins.drive(2'h3, pcin);
         rd(EIVS_ADDR_EXT_FLG, (m != 0) ? 8'h03 : 8'h00);
         obs("irq_req", (m != 0) ? 8'h03 : 8'h00);
      end
      cpu.global_enable <= 1'b0;
      repeat (2) @(posedge clk);
      obs("irq_req", 8'h00);
      cpu.global_enable <= 1'b1;
      cpu.ext_ack <= 2'h3;
      @(posedge clk);
      cpu.ext_ack <= 2'h0;
      rd(EIVS_ADDR_EXT_FLG, 8'h00);
      $display("sense modes done");
      wr(EIVS_ADDR_MSK_LO, 8'h01);
      wr(EIVS_ADDR_MSK_MID, 8'h40);
      wr(EIVS_ADDR_MSK_HI, 8'h80);
      for (int i = 0; i < 5; i++) begin
         u_pins.drive(2'h3, pcin ^ (24'h000001 << pn[i]));
         rd(EIVS_ADDR_PC_FLG, pf[i]);
         obs("irq_req", pf[i] << 2);
         cpu.pc_ack <= 3'h7;
         @(posedge clk);
         cpu.pc_ack <= 3'h0;
      end
      $display("pin change done");
      cpu.boot_side_boot_lock <= 1'b1;
      cpu.exec_in_boot <= 1'b1;
      repeat (3) @(posedge clk);
      obs("irq_block", 8'h01);
      cpu.exec_in_boot <= 1'b0;
      repeat (3) @(posedge clk);
      obs("irq_block", 8'h00);
      cpu.boot_side_boot_lock <= 1'b0;
      cpu.app_side_boot_lock <= 1'b1;
      repeat (3) @(posedge clk);
      obs("irq_block", 8'h00);
      wr(EIVS_ADDR_CPUCTL, 8'h01);
      wr(EIVS_ADDR_CPUCTL, 8'h02);
      repeat (4) @(posedge clk);
      obs("irq_block", 8'h01);
      $display("boot lock done");
      finish_test;
   end
endmodule : eivs_top_bench
`default_nettype wire
